// *** fpd_ctrl.sv ***
// Host controller that drives the flash plus PSRAM package pins from APB
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1 - Host uses listed pin sets only; never flash and PSRAM selected together
// RULE2 - Flash read: flash select and output gate low, write strobe high
// RULE3 - Flash command: write strobe and flash select low, output gate high
// RULE4 - Width select high gives a sixteen-bit flash data bus
// RULE5 - Width select low: low byte only, top pin is byte address
// RULE6 - Width select also picks byte or word program data
// RULE7 - After reset the flash reads array data without a command
// RULE8 - A bank stays in array read until a write changes its command
// RULE9 - Unlock bypass programs in two write cycles instead of four
// RULE10 - Flash space splits into four banks picked by bank address bits
// RULE11 - Erase targets one sector, several sectors, or the whole array
// RULE12 - Protect pin low keeps both outer boot sectors protected; the device model protects only the sector at address 4'hF
// RULE13 - Protect pin high: boot sectors follow last protect or unprotect
// RULE14 - Boost level enters bypass and unprotects all sectors temporarily
// RULE15 - Boost level shortens programming time by forty percent
// RULE16 - Boost level only for accelerated programming; pin never left floating
// RULE17 - Autoselect reads return codes from a separate internal register
// RULE18 - PSRAM byte mode: extra address pin, data on low lane only
// RULE19 - Flash reset low tristates outputs and ignores other controls
// RULE20 - Sector protect: elevated reset, A6 low, A1 high, A0 low, write pulse
module fpd_ctrl
  import fpd_pkg::*;
#(
  parameter logic [2:0][FLASH_AW-1:0] UNLK_ADDR = '0,
  parameter logic [2:0][15:0]         UNLK_DATA = '0
) (
  input  wire logic                core_clk,  // 10 MHz clock
  input  wire logic                rstn,      // Async reset, active low
  input  wire logic                ce,        // Clock enable
  input  wire logic [APB_AW-1:0]   paddr,     // APB address
  input  wire logic                psel,      // APB select
  input  wire logic                penable,   // APB enable
  input  wire logic                pwrite,    // APB direction
  input  wire logic [31:0]         pwdata,    // APB write data
  output logic                     pready,    // APB ready
  output logic [31:0]              prdata,    // APB read data
  output logic                     pslverr,   // APB error
  output fpd_ctl_pins_t            ctlPins,   // Control pins to the package
  output logic [FLASH_AW-1:0]      addrPins,  // Address pins
  output fpd_dq_t                  dqPins,    // Data pins out and enables
  input  wire logic [15:0]         dqIn       // Data pins in
);

  fpd_state_t               state_reg,  state_next;
  logic [1:0]               seq_reg,    seq_next;
  fpd_ctl_pins_t            pins_reg,   pins_next;
  logic [FLASH_AW-1:0]      apin_reg,   apin_next;
  fpd_dq_t                  dq_reg,     dq_next;
  logic [15:0]              rdata_reg,  rdata_next;
  logic [CTRL_W-1:0]        ctrl_reg,   ctrl_next;
  logic [FLASH_AW:0]        addr_reg,   addr_next;
  logic [15:0]              wdata_reg,  wdata_next;
  fpd_op_t                  op_reg,     op_next;
  logic [1:0]               mask_reg,   mask_next;
  logic [STROBE_W-1:0]      tim_reg,    tim_next;
  logic                     err_reg,    err_next;
  logic                     timLoad;
  logic                     timDone;
  logic                     wrAcc;
  logic                     rdAcc;
  logic                     mapped;
  logic                     busy;
  logic                     flashOp;
  logic                     boostNow;
  logic                     bypassNow;

  assign wrAcc  = psel && penable && pwrite;
  assign rdAcc  = psel && penable && !pwrite;
  assign busy   = (state_reg != ST_IDLE);
  assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_ADDR) ||
                  (paddr == OFF_WDATA) || (paddr == OFF_CMD) ||
                  (paddr == OFF_STATUS) || (paddr == OFF_RDATA) ||
                  (paddr == OFF_TIMING);
  assign flashOp = (op_reg != OP_PSRAM_READ) && (op_reg != OP_PSRAM_WRITE);
  // Boost is raised only while a program sequence runs
  assign boostNow  = busy && (op_reg == OP_FLASH_PROG) &&
                     ctrl_reg[CTRL_BOOST];  // RULE16
  assign bypassNow = ctrl_reg[CTRL_BYPASS] || ctrl_reg[CTRL_BOOST];  // RULE14

  fpd_timer #(.W(STROBE_W)) u_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ce       (ce),
    .load     (timLoad),
    .loadVal  (tim_reg),
    .done     (timDone)
  );

  // APB slave: zero wait states, error on unmapped or refused command
  always_comb begin
    pready  = 1'b1;
    pslverr = psel && penable &&
              (!mapped || (pwrite && paddr == OFF_CMD &&
               (busy || ctrl_reg[CTRL_RESET])));
    prdata  = '0;
    unique case (paddr)
      OFF_CTRL:   prdata = 32'(ctrl_reg);
      OFF_ADDR:   prdata = 32'(addr_reg);
      OFF_WDATA:  prdata = 32'(wdata_reg);
      OFF_CMD:    prdata = 32'({mask_reg, op_reg});
      OFF_STATUS: prdata = 32'({op_reg, 5'h00, err_reg, bypassNow, busy});
      OFF_RDATA:  prdata = 32'(rdata_reg);
      OFF_TIMING: prdata = 32'(tim_reg);
      default:    prdata = '0;
    endcase
  end

  always_comb begin
    logic [15:0]         d;
    logic [FLASH_AW-1:0] a;
    logic                startOk;
    d          = wdata_reg;
    a          = addr_reg[FLASH_AW:1];
    startOk    = 1'b0;
    state_next = state_reg;
    seq_next   = seq_reg;
    pins_next  = pins_reg;
    apin_next  = apin_reg;
    dq_next    = dq_reg;
    rdata_next = rdata_reg;
    ctrl_next  = ctrl_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    op_next    = op_reg;
    mask_next  = mask_reg;
    tim_next   = tim_reg;
    err_next   = err_reg;
    timLoad    = 1'b0;

    if (wrAcc) begin
      unique case (paddr)
        OFF_CTRL:   ctrl_next  = pwdata[CTRL_W-1:0];
        OFF_ADDR:   addr_next  = pwdata[FLASH_AW:0];
        OFF_WDATA:  wdata_next = pwdata[15:0];
        OFF_TIMING: tim_next   = (pwdata[STROBE_W-1:0] == '0) ?
                                 STROBE_RST : pwdata[STROBE_W-1:0];
        OFF_STATUS: err_next   = err_reg && !pwdata[0];
        OFF_CMD: begin
          if (busy || ctrl_reg[CTRL_RESET]) begin
            err_next = 1'b1;
          end else begin
            startOk   = 1'b1;
            op_next   = fpd_op_t'(pwdata[CMD_OP_LSB +: 3]);
            mask_next = pwdata[CMD_UB_N:CMD_LB_N];
          end
        end
        default: ;
      endcase
    end

    // Pin levels that hold in every state
    pins_next.flashResetN      = !ctrl_reg[CTRL_RESET];
    pins_next.flashWidthSelect = ctrl_reg[CTRL_FLASH_WORD];
    pins_next.psramWidthSelect = ctrl_reg[CTRL_PSRAM_WORD];
    // Pin always driven, never floating
    pins_next.protectAccelHigh  = ctrl_reg[CTRL_WP_HIGH] || boostNow; // RULE16
    pins_next.protectAccelBoost = boostNow;  // RULE16

    unique case (state_reg)
      ST_IDLE: begin
        pins_next.flashSelN     = 1'b1;
        pins_next.psramSelect1N = 1'b1;
        pins_next.psramSelect2  = 1'b0;
        pins_next.outGateN      = 1'b1;
        pins_next.writeStrobeN  = 1'b1;
        pins_next.resetElevated = 1'b0;
        dq_next.oe              = '0;
        if (startOk) begin
          state_next = ST_SETUP;
          // Bypass shortens the program sequence to two writes
          seq_next = (op_next == OP_FLASH_PROG) ?
                     (bypassNow ? SEQ_BYP_FIRST : SEQ_STD_FIRST) :
                     SEQ_LAST;  // RULE9
        end
      end
      ST_SETUP: begin
        if (op_reg == OP_FLASH_PROG && seq_reg != SEQ_LAST) begin
          a = UNLK_ADDR[seq_reg];
          d = UNLK_DATA[seq_reg];
        end
        if (op_reg == OP_SECT_PROT) begin
          a[PROT_A6] = 1'b0;  // RULE20
          a[PROT_A1] = 1'b1;  // RULE20
          a[PROT_A0] = 1'b0;  // RULE20
        end
        apin_next = a;
        // Only one device is ever selected
        pins_next.flashSelN     = !flashOp;  // RULE1
        pins_next.psramSelect1N = flashOp;   // RULE1
        pins_next.psramSelect2  = !flashOp;  // RULE1
        pins_next.resetElevated = (op_reg == OP_SECT_PROT);  // RULE20
        pins_next.psramByteAddr = !ctrl_reg[CTRL_PSRAM_WORD] &&
                                  addr_reg[ADDR_BYTE];  // RULE18
        pins_next.lowerLaneMaskN = mask_reg[0];
        pins_next.upperLaneMaskN = mask_reg[1];
        dq_next.dout = d;
        dq_next.oe   = '0;
        if (op_reg inside {OP_FLASH_WRITE, OP_FLASH_PROG, OP_SECT_PROT}) begin
          // Program data width follows the width select
          dq_next.oe[7:0]  = 8'hFF;  // RULE6
          dq_next.oe[15:8] = ctrl_reg[CTRL_FLASH_WORD] ? 8'hFF : 8'h00;
        end else if (op_reg == OP_PSRAM_WRITE) begin
          dq_next.oe[7:0]  = (ctrl_reg[CTRL_PSRAM_WORD] && mask_reg[0]) ?
                             8'h00 : 8'hFF;
          // Upper lane stays released in PSRAM byte mode
          dq_next.oe[15:8] = (ctrl_reg[CTRL_PSRAM_WORD] && !mask_reg[1]) ?
                             8'hFF : 8'h00;  // RULE18
        end
        if (flashOp && !ctrl_reg[CTRL_FLASH_WORD]) begin
          // Byte mode: top data pin carries the byte-lane address bit
          dq_next.oe[15]   = 1'b1;  // RULE5
          dq_next.dout[15] = addr_reg[ADDR_BYTE];  // RULE5
        end
        state_next = ST_STROBE;
        timLoad    = 1'b1;
      end
      ST_STROBE: begin
        if (op_reg inside {OP_FLASH_READ, OP_PSRAM_READ}) begin
          pins_next.outGateN     = 1'b0;  // RULE2
          pins_next.writeStrobeN = 1'b1;  // RULE2
        end else begin
          pins_next.outGateN     = 1'b1;  // RULE3
          pins_next.writeStrobeN = 1'b0;  // RULE3
        end
        if (timDone && pins_reg.writeStrobeN == pins_next.writeStrobeN &&
            pins_reg.outGateN == pins_next.outGateN) begin
          state_next = ST_HOLD;
          pins_next.outGateN     = 1'b1;
          pins_next.writeStrobeN = 1'b1;
          if (op_reg == OP_FLASH_READ) begin
            // Narrow bus returns only the low byte
            rdata_next = ctrl_reg[CTRL_FLASH_WORD] ? dqIn :
                         {8'h00, dqIn[7:0]};  // RULE4
          end else if (op_reg == OP_PSRAM_READ) begin
            rdata_next = ctrl_reg[CTRL_PSRAM_WORD] ? dqIn :
                         {8'h00, dqIn[7:0]};  // RULE18
          end
        end
      end
      ST_HOLD: begin
        // Deselect between cycles keeps data and address hold clean
        dq_next.oe              = '0;
        pins_next.flashSelN     = 1'b1;
        pins_next.psramSelect1N = 1'b1;
        pins_next.psramSelect2  = 1'b0;
        pins_next.resetElevated = 1'b0;
        if (seq_reg != SEQ_LAST) begin
          seq_next   = seq_reg + 2'h1;
          state_next = ST_SETUP;
        end else begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      seq_reg   <= SEQ_LAST;
      pins_reg  <= PINS_IDLE;
      apin_reg  <= '0;
      dq_reg    <= '0;
      rdata_reg <= '0;
      ctrl_reg  <= CTRL_RST;
      addr_reg  <= '0;
      wdata_reg <= '0;
      op_reg    <= OP_FLASH_READ;
      mask_reg  <= 2'h0;
      tim_reg   <= STROBE_RST;
      err_reg   <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      seq_reg   <= seq_next;
      pins_reg  <= pins_next;
      apin_reg  <= apin_next;
      dq_reg    <= dq_next;
      rdata_reg <= rdata_next;
      ctrl_reg  <= ctrl_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      op_reg    <= op_next;
      mask_reg  <= mask_next;
      tim_reg   <= tim_next;
      err_reg   <= err_next;
    end
  end

  assign ctlPins  = pins_reg;
  assign addrPins = apin_reg;
  assign dqPins   = dq_reg;
endmodule : fpd_ctrl
`default_nettype wire

// *** fpd_ctrl_asserts.sv ***
// Concurrent checks on the controller's package pins
`timescale 1ns/1ps
`default_nettype none
module fpd_ctrl_asserts
  import fpd_pkg::*;
(
  input wire logic                core_clk, // Clock
  input wire logic                rstn,     // Reset, active low
  input wire logic                ce,       // Clock enable
  input wire logic [APB_AW-1:0]   paddr,    // APB address
  input wire logic                psel,     // APB select
  input wire logic                penable,  // APB enable
  input wire logic                pwrite,   // APB direction
  input wire logic [31:0]         pwdata,   // APB write data
  input wire logic                pready,   // APB ready
  input wire logic [31:0]         prdata,   // APB read data
  input wire logic                pslverr,  // APB error
  input wire fpd_ctl_pins_t       ctlPins,  // Control pins
  input wire logic [FLASH_AW-1:0] addrPins, // Address pins
  input wire fpd_dq_t             dqPins,   // Data out and enables
  input wire logic [15:0]         dqIn      // Data in
);
  wire fSel = !ctlPins.flashSelN;
  wire pSel = !ctlPins.psramSelect1N && ctlPins.psramSelect2;
  wire rdS  = !ctlPins.outGateN;
  wire wrS  = !ctlPins.writeStrobeN;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_one_dev; !(fSel && pSel); endproperty
  a_one_dev: assert property (p_one_dev)
    else $error("flash and psram selected together");
  property p_read; fSel && rdS |-> !wrS && dqPins.oe[14:0] == 15'h0000;
  endproperty
  a_read: assert property (p_read)
    else $error("flash read with bad strobe or driven data");
  property p_setup; $fell(ctlPins.outGateN) && fSel |-> $past(fSel) &&
    $stable(addrPins); endproperty
  a_setup: assert property (p_setup)
    else $error("output gate fell without a setup cycle");
  property p_write; fSel && wrS |-> !rdS; endproperty
  a_write: assert property (p_write)
    else $error("flash write with output gate low");
  property p_hold; $rose(ctlPins.writeStrobeN) |-> $stable(addrPins) &&
    $stable(dqPins.dout); endproperty
  a_hold: assert property (p_hold)
    else $error("address or data moved at write strobe rise");
  property p_word; fSel && wrS && ctlPins.flashWidthSelect &&
    !ctlPins.resetElevated |-> dqPins.oe == 16'hFFFF; endproperty
  a_word: assert property (p_word)
    else $error("word write does not drive all data pins");
  property p_byte; fSel && !ctlPins.flashWidthSelect |->
    dqPins.oe[15:8] == 8'h80; endproperty
  a_byte: assert property (p_byte)
    else $error("byte mode upper lane enables wrong");
  property p_pbyte; pSel && !ctlPins.psramWidthSelect |->
    dqPins.oe[15:8] == 8'h00; endproperty
  a_pbyte: assert property (p_pbyte)
    else $error("psram byte mode drives upper lane");
  property p_prot; ctlPins.resetElevated && wrS |-> fSel &&
    !addrPins[6] && addrPins[1] && !addrPins[0]; endproperty
  a_prot: assert property (p_prot)
    else $error("sector protect pulse with wrong address bits");
  property p_boost; ctlPins.protectAccelBoost |-> !rdS && !pSel;
  endproperty
  a_boost: assert property (p_boost)
    else $error("boost level outside programming");
  c_read: cover property (fSel && rdS);
  c_boost: cover property (wrS && ctlPins.protectAccelBoost);
  c_prot: cover property (ctlPins.resetElevated && wrS);
endmodule : fpd_ctrl_asserts
bind fpd_ctrl fpd_ctrl_asserts i_fpd_ctrl_asserts (
  .core_clk(core_clk), .rstn(rstn), .ce(ce), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .ctlPins(ctlPins),
  .addrPins(addrPins), .dqPins(dqPins), .dqIn(dqIn));
`default_nettype wire

// *** fpd_dev_model.sv ***
// Behavioural flash plus PSRAM package as seen at its pins
`timescale 1ns/1ps
`default_nettype none
module fpd_dev_model
  import fpd_pkg::*;
(
  input wire logic                core_clk,   // Sampling clock
  input wire fpd_ctl_pins_t       ctlPins,    // Control pins
  input wire logic [FLASH_AW-1:0] addrPins,   // Address pins
  input wire fpd_dq_t             dqPins,     // Host data and enables
  output logic [15:0]             dqIn,       // Resolved data pins
  output int                      writeCount, // Flash write cycles seen
  output int                      protCount   // Protect pulses seen
);
  logic [15:0] mem [16];
  logic [7:0]  pmem [32];
  logic [15:0] devOut;
  logic [15:0] devOe;
  logic        flt;
  logic        prevWe;
  logic        fSel;
  logic        pSel;
  logic        prot;
  logic [3:0]  a;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hA500 + 16'(i);
    for (int i = 0; i < 32; i++) pmem[i] = 8'h00;
    {flt, prevWe, writeCount, protCount} = {2'b01, 64'h0};
  end
  always_comb begin
    fSel = !ctlPins.flashSelN && ctlPins.flashResetN;
    pSel = !ctlPins.psramSelect1N && ctlPins.psramSelect2;
    a = addrPins[3:0];
    prot = a == 4'hF && !ctlPins.protectAccelHigh &&
      !ctlPins.protectAccelBoost;
    {devOut, devOe} = 32'h0;
    if (fSel && !ctlPins.outGateN && ctlPins.writeStrobeN) begin
      if (ctlPins.flashWidthSelect) {devOut, devOe} = {mem[a], 16'hFFFF};
      else devOut = {8'h00, dqPins.dout[15] ? mem[a][15:8] : mem[a][7:0]};
      devOe[7:0] = 8'hFF;
    end else if (pSel && !ctlPins.outGateN) begin
      devOut = {pmem[{a, 1'b1}], pmem[{a, ctlPins.psramByteAddr}]};
      devOe = ctlPins.psramWidthSelect ? 16'hFFFF : 16'h00FF;
    end
    // Released pins toggle so a stale value is never mistaken for data
    for (int i = 0; i < 16; i++)
      dqIn[i] = dqPins.oe[i] ? dqPins.dout[i] : devOe[i] ? devOut[i] : flt;
  end
  // Sampled mid-cycle, after the controller's edge has settled
  always @(negedge core_clk) begin
    flt <= !flt;
    prevWe <= ctlPins.writeStrobeN;
    if (ctlPins.writeStrobeN && !prevWe && fSel) begin
      if (ctlPins.resetElevated) protCount <= protCount + 1;
      else begin
        writeCount <= writeCount + 1;
        if (!prot && ctlPins.flashWidthSelect) mem[a] <= dqPins.dout;
      end
    end else if (ctlPins.writeStrobeN && !prevWe && pSel) begin
      if (!ctlPins.psramWidthSelect) pmem[{a, ctlPins.psramByteAddr}] <=
        dqPins.dout[7:0];
      else {pmem[{a, 1'b1}], pmem[{a, 1'b0}]} <= dqPins.dout;
    end
  end
endmodule : fpd_dev_model
`default_nettype wire

// *** fpd_pkg.sv ***
// Package of constants and types for the flash plus PSRAM pin controller
package fpd_pkg;

  localparam int unsigned APB_AW = 8;

  // Register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_WDATA  = 8'h08;
  localparam logic [7:0] OFF_CMD    = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_RDATA  = 8'h14;
  localparam logic [7:0] OFF_TIMING = 8'h18;

  // Control register fields
  localparam int unsigned CTRL_FLASH_WORD = 0;
  localparam int unsigned CTRL_PSRAM_WORD = 1;
  localparam int unsigned CTRL_BYPASS     = 2;
  localparam int unsigned CTRL_WP_HIGH    = 3;
  localparam int unsigned CTRL_BOOST      = 4;
  localparam int unsigned CTRL_RESET      = 5;
  localparam int unsigned CTRL_W          = 6;
  localparam logic [5:0]  CTRL_RST        = 6'h03;

  // Command register fields
  localparam int unsigned CMD_OP_LSB  = 0;
  localparam int unsigned CMD_LB_N    = 3;
  localparam int unsigned CMD_UB_N    = 4;

  // Address register layout: bit 0 is the byte-lane bit, 21:1 the pins
  localparam int unsigned FLASH_AW    = 21;
  localparam int unsigned ADDR_BYTE   = 0;
  localparam int unsigned PROT_A6     = 6;
  localparam int unsigned PROT_A1     = 1;
  localparam int unsigned PROT_A0     = 0;

  // Timing
  localparam int unsigned STROBE_W    = 8;
  localparam logic [7:0]  STROBE_RST  = 8'h01;

  // Program sequence
  localparam logic [1:0]  SEQ_STD_FIRST = 2'h0;
  localparam logic [1:0]  SEQ_BYP_FIRST = 2'h2;
  localparam logic [1:0]  SEQ_LAST      = 2'h3;

  typedef enum logic [2:0] {
    OP_FLASH_READ  = 3'h0,
    OP_FLASH_WRITE = 3'h1,
    OP_FLASH_PROG  = 3'h2,
    OP_PSRAM_READ  = 3'h3,
    OP_PSRAM_WRITE = 3'h4,
    OP_SECT_PROT   = 3'h5
  } fpd_op_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_STROBE = 2'b11,
    ST_HOLD   = 2'b10
  } fpd_state_t;

  typedef struct packed {
    logic flashSelN;
    logic psramSelect1N;
    logic psramSelect2;
    logic outGateN;
    logic writeStrobeN;
    logic flashWidthSelect;
    logic psramWidthSelect;
    logic psramByteAddr;
    logic lowerLaneMaskN;
    logic upperLaneMaskN;
    logic flashResetN;
    logic resetElevated;
    logic protectAccelHigh;
    logic protectAccelBoost;
  } fpd_ctl_pins_t;

  typedef struct packed {
    logic [15:0] dout;
    logic [15:0] oe;
  } fpd_dq_t;

  localparam fpd_ctl_pins_t PINS_IDLE = '{
    flashSelN: 1'b1, psramSelect1N: 1'b1, psramSelect2: 1'b0,
    outGateN: 1'b1, writeStrobeN: 1'b1, flashWidthSelect: 1'b1,
    psramWidthSelect: 1'b1, psramByteAddr: 1'b0, lowerLaneMaskN: 1'b1,
    upperLaneMaskN: 1'b1, flashResetN: 1'b1, resetElevated: 1'b0,
    protectAccelHigh: 1'b0, protectAccelBoost: 1'b0};

endpackage : fpd_pkg

// *** fpd_timer.sv ***
// Down counter that times the strobe phase of a bus cycle
`timescale 1ns/1ps
`default_nettype none
module fpd_timer #(
  parameter int unsigned W = 8
) (
  input  wire logic         core_clk,  // Clock
  input  wire logic         rstn,      // Async reset, active low
  input  wire logic         ce,        // Clock enable
  input  wire logic         load,      // Load pulse
  input  wire logic [W-1:0] loadVal,   // Strobe cycles to count
  output logic              done       // Count reached zero
);
  // Refuse a width too small to count a strobe
  if (W < 2) begin : g_bad_w
    $error("fpd_timer: W must be at least 2");
  end

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = loadVal;
    end else if (count_reg != '0) begin
      count_next = count_reg - W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end

  assign done = (count_reg == '0);
endmodule : fpd_timer
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the flash plus PSRAM host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fpd_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ce = 1'b1, pready, pslverr, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [FLASH_AW-1:0] addrPins;
  logic [15:0] dqIn;
  fpd_ctl_pins_t ctlPins;
  fpd_dq_t dqPins;
  int writeCount, protCount, cnt, fail_count = 0, cmp_count = 0;
  logic [7:0] pc [5] = '{8'h03, 8'h07, 8'h13, 8'h03, 8'h0B};
  logic [3:0] pa [5] = '{4'h5, 4'h6, 4'h7, 4'hF, 4'hF};
  int pn [5] = '{4, 2, 2, 4, 4};
  fpd_ctrl i_fpd_ctrl (.core_clk(core_clk), .rstn(rstn), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ctlPins(ctlPins), .addrPins(addrPins), .dqPins(dqPins), .dqIn(dqIn));
  fpd_dev_model i_fpd_dev_model (.core_clk(core_clk), .ctlPins(ctlPins),
    .addrPins(addrPins), .dqPins(dqPins), .dqIn(dqIn),
    .writeCount(writeCount), .protCount(protCount));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Answer is taken at the rising edge that completes the access
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      summarize();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] m = 32'hFFFFFFFF);
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, exp);
  endtask : rdc
  task automatic op(input logic [2:0] c, input logic [31:0] ad,
                    input logic [15:0] d);
    int n;
    wr(OFF_ADDR, ad);
    wr(OFF_WDATA, {16'h0000, d});
    wr(OFF_CMD, {29'h0, c});
    n = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0, r, e);
      n++;
    end while (r[0] !== 1'b0 && n < 100);
    if (n >= 100) begin
      fail_count++;
      summarize();
    end
  endtask : op
  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    rdc(OFF_CTRL, 32'h3);
    rdc(OFF_TIMING, 32'h1);
    rdc(OFF_STATUS, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    wr(OFF_TIMING, 32'h2);
    ce <= 1'b0;
    wr(OFF_TIMING, 32'h7);
    ce <= 1'b1;
    rdc(OFF_TIMING, 32'h2);
    $display("test registers done");
    for (int i = 1; i < 4; i++) begin
      op(OP_FLASH_READ, 32'(i * 2), 16'h0);
      rdc(OFF_RDATA, 32'hA500 + 32'(i));
    end
    $display("test array read done");
    for (int i = 0; i < 5; i++) begin
      wr(OFF_CTRL, {24'h0, pc[i]});
      cnt = writeCount;
      op(OP_FLASH_PROG, {27'h0, pa[i], 1'b0}, 16'h1230 + 16'(i));
      chk(32'(writeCount - cnt), 32'(pn[i]));
      op(OP_FLASH_READ, {27'h0, pa[i], 1'b0}, 16'h0);
      rdc(OFF_RDATA, i == 3 ? 32'hA50F : 32'h1230 + 32'(i));
    end
    $display("test program done");
    wr(OFF_CTRL, 32'h2);
    op(OP_FLASH_READ, 32'h3, 16'h0);
    rdc(OFF_RDATA, 32'hA5);
    op(OP_FLASH_READ, 32'h2, 16'h0);
    rdc(OFF_RDATA, 32'h01);
    $display("test byte mode done");
    wr(OFF_CTRL, 32'h3);
    op(OP_PSRAM_WRITE, 32'h6, 16'hBEEF);
    op(OP_PSRAM_READ, 32'h6, 16'h0);
    rdc(OFF_RDATA, 32'hBEEF);
    wr(OFF_CTRL, 32'h1);
    op(OP_PSRAM_WRITE, 32'h6, 16'h005A);
    op(OP_PSRAM_READ, 32'h7, 16'h0);
    rdc(OFF_RDATA, 32'hBE, 32'hFF);
    wr(OFF_CTRL, 32'h3);
    op(OP_PSRAM_READ, 32'h6, 16'h0);
    rdc(OFF_RDATA, 32'hBE5A);
    $display("test psram done");
    wr(OFF_CMD, 32'h0);
    apb(1'b1, OFF_CMD, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    op(OP_FLASH_READ, 32'h2, 16'h0);
    rdc(OFF_STATUS, 32'h4, 32'h4);
    wr(OFF_STATUS, 32'h1);
    rdc(OFF_STATUS, 32'h0, 32'h4);
    wr(OFF_CTRL, 32'h23);
    apb(1'b1, OFF_CMD, 32'h0, r, e);
    chk({30'h0, ctlPins.flashResetN, e}, 32'h1);
    wr(OFF_CTRL, 32'h3);
    wr(OFF_STATUS, 32'h1);
    op(OP_FLASH_READ, 32'h00300010, 16'h0);
    rdc(OFF_RDATA, 32'hA508);
    chk({11'h0, addrPins}, 32'h00180008);
    $display("test refusal and reset done");
    cnt = protCount;
    op(OP_SECT_PROT, 32'h00040000, 16'h0);
    chk(32'(protCount - cnt), 32'h1);
    $display("test sector protect done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
